// ===== src/cdgs_edge_div.sv
// Edge clock divider: divides a sampled source clock by two, four or eight
// Assumes control inputs come from logic on the same clock
module cdgs_edge_div
   import cdgs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Divider control
   input  wire logic       div_rst_in,
   input  wire logic       release_in,
   input  wire logic [1:0] mode_in,
   // Source and divided outputs
   input  wire logic       src_in,
   output logic            div_clk_out,
   output logic            div_en_out,
   output logic            run_out
);
   logic [2:0] cnt_ff;
   logic       run_ff;
   logic       src_d_ff;
   logic       div_en_ff;
   logic       rise;

   assign rise = src_in & ~src_d_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) src_d_ff <= 1'b0;
      else src_d_ff <= src_in;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || div_rst_in) run_ff <= 1'b0;
      else if (release_in) run_ff <= 1'b1;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || div_rst_in || !run_ff) cnt_ff <= 3'h0;
      else if (rise) cnt_ff <= cnt_ff + 3'h1;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || div_rst_in) div_en_ff <= 1'b0;
      else div_en_ff <= run_ff & rise & ~div_tap(cnt_ff, mode_in)
                        & div_tap(cnt_ff + 3'h1, mode_in);
   end

   // Divider reset forces the clock and enable outputs low without waiting for an edge; run_out clears at the next edge
   assign div_clk_out = div_tap(cnt_ff, mode_in) & run_ff & ~div_rst_in;
   assign div_en_out  = div_en_ff & ~div_rst_in;
   assign run_out     = run_ff;

   property p_div2_toggle;
      @(posedge clk_in) disable iff (!rst_n_in)
      (run_ff && rise && !div_rst_in && mode_in == DIV_BY2) |=>
         (div_clk_out != $past(div_clk_out)) || div_rst_in;
   endproperty
   a_div2_toggle: assert property (p_div2_toggle)
      else $error("divide by two output did not toggle");
   property p_rst_low;
      @(posedge clk_in) disable iff (!rst_n_in)
      div_rst_in |-> !div_clk_out && !div_en_out;
   endproperty
   a_rst_low: assert property (p_rst_low)
      else $error("divider output high during reset");
   property p_release_phase;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(run_ff) |-> $past(release_in) && cnt_ff == 3'h0;
   endproperty
   a_release_phase: assert property (p_release_phase)
      else $error("divider start not tied to release");
endmodule : cdgs_edge_div

// ===== src/cdgs_glitchless_sel.sv
// Glitchless two-input clock selector for one primary line
// Assumes both inputs are sampled clocks on the system clock
module cdgs_glitchless_sel
   import cdgs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Candidate clocks and select
   input  wire logic clk_a_in,
   input  wire logic clk_b_in,
   input  wire logic sel_in,
   // Selected clock and state
   output logic      clk_out,
   output logic      cur_out,
   output logic      hold_out
);
   cdgs_sel_e state_ff;
   cdgs_sel_e nxt_state;
   logic      cur_ff;
   logic      out_ff;
   logic      nxt_cur;
   logic      nxt_out;
   logic      cur_clk;
   logic      new_clk;

   assign cur_clk = cur_ff ? clk_b_in : clk_a_in;
   assign new_clk = sel_in ? clk_b_in : clk_a_in;

   always_comb begin
      nxt_state = state_ff;
      nxt_cur   = cur_ff;
      nxt_out   = out_ff;
      unique case (state_ff)
         SEL_FOLLOW: begin
            if (sel_in != cur_ff && !cur_clk) begin
               nxt_state = SEL_HOLD;
               nxt_out   = 1'b0;
            end else begin
               nxt_out = cur_clk;
            end
         end
         SEL_HOLD: begin
            nxt_out = 1'b0;
            if (!new_clk) begin
               nxt_cur   = sel_in;
               nxt_state = SEL_FOLLOW;
            end
         end
         default: begin
            nxt_state = SEL_HOLD;
            nxt_out   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_ff <= SEL_FOLLOW;
         cur_ff   <= 1'b0;
         out_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cur_ff   <= nxt_cur;
         out_ff   <= nxt_out;
      end
   end

   assign clk_out  = out_ff;
   assign cur_out  = cur_ff;
   assign hold_out = (state_ff == SEL_HOLD);

   sequence s_old_low;
      state_ff == SEL_FOLLOW && sel_in != cur_ff && !cur_clk;
   endsequence
   sequence s_parked;
      !clk_out && state_ff == SEL_HOLD;
   endsequence
   property p_park;
      @(posedge clk_in) disable iff (!rst_n_in) s_old_low |=> s_parked;
   endproperty
   a_park: assert property (p_park)
      else $error("selector did not park low on switch");
   property p_rise_clean;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(clk_out) |-> $past(state_ff == SEL_FOLLOW && cur_clk);
   endproperty
   a_rise_clean: assert property (p_rise_clean)
      else $error("selector output rose without its source");
   property p_hold_low;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_ff == SEL_HOLD) |=> !clk_out;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("selector output high while parked");
endmodule : cdgs_glitchless_sel

// ===== src/cdgs_pkg.sv
// Constants, types and helpers for the clock divide, gate and select block
// Assumes one system clock; clock sources arrive as sampled levels
package cdgs_pkg;
   localparam int NUM_QUAD   = 4;
   localparam int NUM_LINE   = 8;
   localparam int NUM_EXT    = 8;
   localparam int NUM_POOL   = NUM_EXT + 1;
   localparam int NUM_SEC    = 8;
   localparam int NUM_REGION = 2;
   localparam int NUM_SLICE  = 3;
   localparam int SEL_W      = 4;
   localparam int SLC_W      = 8;
   localparam int SLC_CTL    = 4;
   localparam int LINE_SIX   = 6;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_DCS    = 8'h04;
   localparam logic [7:0] OFS_STAT   = 8'h08;
   localparam logic [7:0] OFS_CMUX0  = 8'h10;
   localparam logic [7:0] OFS_SLICE0 = 8'h20;
   localparam logic [7:0] REG_STRIDE = 8'h04;
   // Control register fields
   localparam int CTL_MODE = 0;
   localparam int CTL_DRST = 2;
   localparam int CTL_REL  = 3;
   localparam int CTL_GATE = 4;
   localparam int CTL_DSRC = 8;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_00f4;
   localparam logic [31:0] CMUX_RST = 32'h7654_3210;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   // Select codes
   localparam logic [3:0] SEL_DIV  = 4'h8;
   localparam logic [3:0] SLC_NONE = 4'h0;
   localparam logic [3:0] SLC_PRI  = 4'h1;
   localparam logic [3:0] SLC_SEC  = 4'h9;
   localparam logic [3:0] SEC_GAP  = 4'h3;
   localparam logic [2:0] CTL_NONE = 3'h0;
   localparam logic [2:0] CTL_SC7  = 3'h5;
   localparam int         SC_LAST  = 7;
   typedef enum logic [1:0] {
      DIV_BY2 = 2'b00, DIV_BY4 = 2'b01, DIV_BY8 = 2'b10
   } cdgs_mode_e;
   typedef enum logic [1:0] {SEL_FOLLOW = 2'b01, SEL_HOLD = 2'b10} cdgs_sel_e;

   // Accept a new level once the second and third stages agree
   function automatic logic [7:0] sync_agree(input logic [7:0] s2,
      input logic [7:0] s3, input logic [7:0] old);
      return (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
   endfunction : sync_agree

   function automatic logic pick_src(input logic [NUM_POOL-1:0] pool,
      input logic [3:0] sel);
      return (int'(sel) < NUM_POOL) ? pool[sel] : 1'b0;
   endfunction : pick_src

   function automatic logic div_tap(input logic [2:0] cnt,
      input logic [1:0] mode);
      return (mode == DIV_BY8) ? cnt[2] : (mode == DIV_BY4) ? cnt[1] : cnt[0];
   endfunction : div_tap

   // Slice clock: primaries, then secondaries 0-2 and 4-7, none gives one
   function automatic logic slice_clk(input logic [3:0] sel,
      input logic [7:0] pri, input logic [7:0] sec);
      logic [3:0] k;
      k = sel - SLC_SEC;
      if (sel == SLC_NONE) return 1'b1;
      if (sel < SLC_SEC) return pri[3'(sel - SLC_PRI)];
      return sec[(k < SEC_GAP) ? 3'(k) : 3'(k + 4'h1)];
   endfunction : slice_clk

   // Slice control: secondaries 0-3 and 7, none or illegal gives one
   function automatic logic slice_ctl(input logic [2:0] sel,
      input logic [7:0] sec);
      if (sel == CTL_NONE || sel > CTL_SC7) return 1'b1;
      if (sel == CTL_SC7) return sec[SC_LAST];
      return sec[sel - 3'h1];
   endfunction : slice_ctl
endpackage : cdgs_pkg

// ===== src/cdgs_top.sv
// Clock divide, quadrant gate, glitchless select and slice clock muxes
// Assumes an AHB-Lite master on CLK_IN; clock sources are sampled levels
module cdgs_top
   import cdgs_pkg::*;
(
   // Clock and reset
   input  wire logic                               CLK_IN,
   input  wire logic                               RST_N_IN,
   // AHB-Lite slave
   input  wire logic                               HSEL_IN,
   input  wire logic [31:0]                        HADDR_IN,
   input  wire logic [1:0]                         HTRANS_IN,
   input  wire logic                               HWRITE_IN,
   input  wire logic [2:0]                         HSIZE_IN,
   input  wire logic [31:0]                        HWDATA_IN,
   input  wire logic                               HREADY_IN,
   output logic      [31:0]                        HRDATA_OUT,
   output logic                                    HREADYOUT_OUT,
   output logic                                    HRESP_OUT,
   // Clock sources from pins, PLL, DLL, delay lines and routing
   input  wire logic [NUM_EXT-1:0]                 CLK_SRC_IN,
   input  wire logic [NUM_SEC-1:0]                 SEC_SRC_IN,
   // Divider outputs
   output logic                                    DIV_CLK_OUT,
   output logic                                    DIV_EN_OUT,
   // Quadrant primary lines and slice clocks and controls
   output logic      [NUM_QUAD*NUM_LINE-1:0]       QUAD_CLK_OUT,
   output logic      [NUM_REGION*NUM_SLICE-1:0]    SLICE_CLK_OUT,
   output logic      [NUM_REGION*NUM_SLICE-1:0]    SLICE_CTRL_OUT
);
   localparam int NQL = NUM_QUAD * NUM_LINE;
   localparam int NSL = NUM_REGION * NUM_SLICE;
   localparam int NDS = NUM_QUAD * 2;

   // Bus state
   logic                   take;
   logic                   wr_ph_ff;
   logic                   rd_pend_ff;
   logic [7:0]             addr_ff;
   logic [31:0]            hrdata_ff;
   logic [31:0]            rd_data;
   // Registers
   logic [31:0]            ctrl_ff;
   logic [NDS-1:0]         dcs_ff;
   logic [31:0]            cmux_ff [NUM_QUAD];
   logic [SLC_W*NUM_SLICE-1:0] slice_ff [NUM_REGION];
   // Synchronisers
   logic [NUM_EXT-1:0]     src_s1_ff;
   logic [NUM_EXT-1:0]     src_s2_ff;
   logic [NUM_EXT-1:0]     src_s3_ff;
   logic [NUM_EXT-1:0]     src_ff;
   logic [NUM_SEC-1:0]     sec_s1_ff;
   logic [NUM_SEC-1:0]     sec_s2_ff;
   logic [NUM_SEC-1:0]     sec_s3_ff;
   logic [NUM_SEC-1:0]     sec_ff;
   // Clock network
   logic                   div_clk;
   logic                   div_run;
   logic [NUM_POOL-1:0]    pool;
   logic [NQL-1:0]         cm;
   logic [NQL-1:0]         ln;
   logic [NQL-1:0]         gate_ff;
   logic [NQL-1:0]         quad_ff;
   logic [NDS-1:0]         dcs_clk;
   logic [NDS-1:0]         dcs_cur;
   logic [NDS-1:0]         dcs_hold;
   logic [NSL-1:0]         slc_clk_ff;
   logic [NSL-1:0]         slc_ctl_ff;

   // Bus: writes complete with no wait, reads take one wait state
   assign take = HSEL_IN & HREADY_IN & HTRANS_IN[1];

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         wr_ph_ff   <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end else if (HREADY_IN) begin
         wr_ph_ff   <= take & HWRITE_IN;
         rd_pend_ff <= take & ~HWRITE_IN;
         if (take) addr_ff <= HADDR_IN[7:0];
      end else begin
         wr_ph_ff   <= 1'b0;
         rd_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) hrdata_ff <= ZERO_RST;
      else if (rd_pend_ff) hrdata_ff <= rd_data;
   end

   always_comb begin
      rd_data = ZERO_RST;
      if (addr_ff == OFS_CTRL) rd_data = ctrl_ff;
      if (addr_ff == OFS_DCS) rd_data = {24'h0, dcs_ff};
      if (addr_ff == OFS_STAT)
         rd_data = {8'h00, dcs_hold, dcs_cur, 6'h00, div_clk, div_run};
      for (int q = 0; q < NUM_QUAD; q++) begin
         if (addr_ff == OFS_CMUX0 + 8'(q) * REG_STRIDE) rd_data = cmux_ff[q];
      end
      for (int r = 0; r < NUM_REGION; r++) begin
         if (addr_ff == OFS_SLICE0 + 8'(r) * REG_STRIDE)
            rd_data = {8'h00, slice_ff[r]};
      end
   end

   assign HRDATA_OUT    = hrdata_ff;
   assign HREADYOUT_OUT = ~rd_pend_ff;
   assign HRESP_OUT     = 1'b0;

   // Control and selector registers
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ctrl_ff <= CTRL_RST;
         dcs_ff  <= '0;
      end else if (wr_ph_ff) begin
         if (addr_ff == OFS_CTRL) ctrl_ff <= HWDATA_IN;
         if (addr_ff == OFS_DCS) dcs_ff <= HWDATA_IN[NDS-1:0];
      end
   end

   // Center mux select registers, one nibble per line
   always_ff @(posedge CLK_IN) begin
      for (int q = 0; q < NUM_QUAD; q++) begin
         if (!RST_N_IN) cmux_ff[q] <= CMUX_RST;
         else if (wr_ph_ff && addr_ff == OFS_CMUX0 + 8'(q) * REG_STRIDE)
            cmux_ff[q] <= HWDATA_IN;
      end
   end

   // Slice select registers; slice three has none
   always_ff @(posedge CLK_IN) begin
      for (int r = 0; r < NUM_REGION; r++) begin
         if (!RST_N_IN) slice_ff[r] <= '0;
         else if (wr_ph_ff && addr_ff == OFS_SLICE0 + 8'(r) * REG_STRIDE)
            slice_ff[r] <= HWDATA_IN[SLC_W*NUM_SLICE-1:0];
      end
   end

   // Source synchronisers
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         src_s1_ff <= '0;
         src_s2_ff <= '0;
         src_s3_ff <= '0;
         src_ff    <= '0;
      end else begin
         src_s1_ff <= CLK_SRC_IN;
         src_s2_ff <= src_s1_ff;
         src_s3_ff <= src_s2_ff;
         src_ff    <= sync_agree(src_s2_ff, src_s3_ff, src_ff);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         sec_s1_ff <= '0;
         sec_s2_ff <= '0;
         sec_s3_ff <= '0;
         sec_ff    <= '0;
      end else begin
         sec_s1_ff <= SEC_SRC_IN;
         sec_s2_ff <= sec_s1_ff;
         sec_s3_ff <= sec_s2_ff;
         sec_ff    <= sync_agree(sec_s2_ff, sec_s3_ff, sec_ff);
      end
   end

   // Edge clock divider fed from a chosen source
   cdgs_edge_div u_div (
      .clk_in      (CLK_IN),
      .rst_n_in    (RST_N_IN),
      .div_rst_in  (ctrl_ff[CTL_DRST]),
      .release_in  (ctrl_ff[CTL_REL]),
      .mode_in     (ctrl_ff[CTL_MODE +: 2]),
      .src_in      (src_ff[ctrl_ff[CTL_DSRC +: 3]]),
      .div_clk_out (div_clk),
      .div_en_out  (DIV_EN_OUT),
      .run_out     (div_run)
   );

   assign DIV_CLK_OUT = div_clk;
   assign pool = {div_clk, src_ff};

   // Center muxes: any source onto any line of any quadrant
   always_comb begin
      for (int i = 0; i < NQL; i++) begin
         cm[i] = pick_src(pool, cmux_ff[i / NUM_LINE][(i % NUM_LINE) * SEL_W
                          +: SEL_W]);
      end
   end

   // Two selectors per quadrant on lines six and seven
   for (genvar d = 0; d < NDS; d++) begin : g_dcs
      cdgs_glitchless_sel u_sel (
         .clk_in   (CLK_IN),
         .rst_n_in (RST_N_IN),
         .clk_a_in (cm[(d / 2) * NUM_LINE + LINE_SIX]),
         .clk_b_in (cm[(d / 2) * NUM_LINE + LINE_SIX + 1]),
         .sel_in   (dcs_ff[d]),
         .clk_out  (dcs_clk[d]),
         .cur_out  (dcs_cur[d]),
         .hold_out (dcs_hold[d])
      );
   end

   always_comb begin
      for (int i = 0; i < NQL; i++) begin
         if (i % NUM_LINE >= LINE_SIX)
            ln[i] = dcs_clk[(i / NUM_LINE) * 2 + i % NUM_LINE
                            - LINE_SIX];
         else
            ln[i] = cm[i];
      end
   end

   // Gate enable changes only while the line is low, so no runt pulse
   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < NQL; i++) begin
         if (!RST_N_IN) gate_ff[i] <= 1'b1;
         else if (!ln[i]) gate_ff[i] <= ctrl_ff[CTL_GATE + i / NUM_LINE];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) quad_ff <= '0;
      else quad_ff <= ln & gate_ff;
   end

   assign QUAD_CLK_OUT = quad_ff;

   // Slice clock and control muxes, region r fed by quadrant r
   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < NSL; i++) begin
         if (!RST_N_IN) begin
            slc_clk_ff[i] <= 1'b1;
            slc_ctl_ff[i] <= 1'b1;
         end else begin
            slc_clk_ff[i] <= slice_clk(
               slice_ff[i / NUM_SLICE][(i % NUM_SLICE) * SLC_W +: SEL_W],
               quad_ff[(i / NUM_SLICE) * NUM_LINE +: NUM_LINE],
               sec_ff);
            slc_ctl_ff[i] <= slice_ctl(
               slice_ff[i / NUM_SLICE][(i % NUM_SLICE) * SLC_W + SLC_CTL +: 3],
               sec_ff);
         end
      end
   end

   assign SLICE_CLK_OUT  = slc_clk_ff;
   assign SLICE_CTRL_OUT = slc_ctl_ff;

   property p_slice_none;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (slice_ff[0][SEL_W-1:0] == SLC_NONE && slice_ff[0][SLC_CTL +: 3] ==
       CTL_NONE) |=> SLICE_CLK_OUT[0] && SLICE_CTRL_OUT[0];
   endproperty
   a_slice_none: assert property (p_slice_none)
      else $error("unselected slice mux not at one");

   sequence s_gate_shut;
      !ctrl_ff[CTL_GATE] && !ln[0];
   endsequence
   property p_gate_off;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      s_gate_shut |=> !gate_ff[0] ##1 !QUAD_CLK_OUT[0];
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("gated quadrant line still toggles");

   property p_line_six;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      ##1 QUAD_CLK_OUT[LINE_SIX] == $past(dcs_clk[0] & gate_ff[LINE_SIX]);
   endproperty
   a_line_six: assert property (p_line_six)
      else $error("line six not driven by its selector");

   property p_div_route;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (cmux_ff[1][SEL_W-1:0] == SEL_DIV) |=>
         QUAD_CLK_OUT[NUM_LINE] == $past(div_clk & gate_ff[NUM_LINE]);
   endproperty
   a_div_route: assert property (p_div_route)
      else $error("divider not routed as a primary source");

   property p_ctl_sc7;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (slice_ff[0][SLC_CTL +: 3] == CTL_SC7) |=>
         SLICE_CTRL_OUT[0] == $past(sec_ff[SC_LAST]);
   endproperty
   a_ctl_sc7: assert property (p_ctl_sc7)
      else $error("secondary seven not on slice control");

   property p_read_wait;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (take && !HWRITE_IN) |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read wait state wrong");
endmodule : cdgs_top

// ===== verif/cdgs_fabric_model.sv
// Fabric-side consumer: counts rises of four watched clocks
// Assumes watched clocks are levels sampled on the system clock
module cdgs_fabric_model (
   // Clock and clear
   input  wire logic            clk_in,
   input  wire logic            clr_in,
   // Watched clocks, counts and shortest high run of clock three
   input  wire logic [3:0]      sig_in,
   output logic      [3:0][7:0] cnt_out,
   output logic      [7:0]      min_hi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] last_ff;
   logic [7:0] run_ff;
   always_ff @(posedge clk_in) begin
      last_ff <= sig_in;
      for (int i = 0; i < 4; i++) begin
         if (clr_in) cnt_out[i] <= 8'h00;
         else if (sig_in[i] && !last_ff[i])
            cnt_out[i] <= cnt_out[i] + 8'h01;
      end
   end
   // A runt shows up as a short high run
   always_ff @(posedge clk_in) begin
      if (clr_in) min_hi_out <= 8'hff;
      else if (!sig_in[3] && run_ff != 8'h00 && run_ff < min_hi_out)
         min_hi_out <= run_ff;
      run_ff <= (clr_in || !sig_in[3]) ? 8'h00 : run_ff + 8'h01;
   end
endmodule : cdgs_fabric_model

// ===== verif/cdgs_top_test.sv
// Bench for the clock divide, gate and select block
// Assumes the fabric model counts edges on the watched lines
module cdgs_top_test
   import cdgs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk, rst_n, hwrite, clr, hready, hresp, dclk, den;
   logic [1:0]      htrans;
   logic [31:0]     haddr, hwdata, hrdata, rd, quad;
   logic [7:0]      src, sec, min_hi, p;
   logic [7:0]      den_cnt_ff;
   logic [5:0]      slc, sctl;
   logic [3:0][7:0] cnt;
   int              failures, cmp_count;
   cdgs_top uut (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(1'b1),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
      .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .CLK_SRC_IN(src), .SEC_SRC_IN(sec), .DIV_CLK_OUT(dclk),
      .DIV_EN_OUT(den), .QUAD_CLK_OUT(quad), .SLICE_CLK_OUT(slc),
      .SLICE_CTRL_OUT(sctl));
   cdgs_fabric_model fab (.clk_in(clk), .clr_in(clr),
      .sig_in({quad[6], quad[8], quad[0], dclk}), .cnt_out(cnt),
      .min_hi_out(min_hi));
   // Divider enable pulses since the last clear
   always_ff @(posedge clk) begin
      if (clr) den_cnt_ff <= 8'h00;
      else if (den) den_cnt_ff <= den_cnt_ff + 8'h01;
   end
   task automatic print_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Called just after a rising edge; returns at the edge that ends it
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk
   task automatic tog(input int b, input int h, input int n);
      repeat (n) begin
         src[b] <= 1'b1;
         repeat (h) @(posedge clk);
         src[b] <= 1'b0;
         repeat (h) @(posedge clk);
      end
      repeat (10) @(posedge clk);
   endtask : tog
   task automatic clear;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clear
   function automatic logic exp_clk(input int c, input logic [7:0] v);
      int sc[7] = '{0, 1, 2, 4, 5, 6, 7};
      if (c == 0) return 1'b1;
      if (c < 9) return v[c - 1];
      return ~v[sc[c - 9]];
   endfunction : exp_clk
   function automatic logic exp_ctl(input int c, input logic [7:0] v);
      if (c == 0 || c > 5) return 1'b1;
      return (c == 5) ? ~v[7] : ~v[c - 1];
   endfunction : exp_ctl
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (10000) @(posedge clk);
      failures++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      src = 8'h00;
      sec = 8'h00;
      clr = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(OFS_CTRL, CTRL_RST);
      rdchk(OFS_CMUX0, CMUX_RST);
      rdchk(OFS_SLICE0, ZERO_RST);
      chk(32'(hresp), 32'h0);
      chk(32'({slc, sctl}), 32'hfff);
      bus(1'b1, 8'h0c, 32'hffff_ffff);
      rdchk(8'h0c, ZERO_RST);
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, OFS_CTRL, 32'hf4 | 32'(m));
         bus(1'b1, OFS_CTRL, 32'hf8 | 32'(m));
         clear();
         tog(0, 4, (1 << m) - 1);
         chk(32'(cnt[0]), 32'h0);
         tog(0, 4, 17 - (1 << m));
         chk(32'(cnt[0]), 32'(8 >> m));
         chk(32'(den_cnt_ff), 32'(8 >> m));
      end
      tog(0, 4, 4);
      chk(32'(dclk), 32'h1);
      bus(1'b1, OFS_CTRL, 32'hfe);
      @(posedge clk);
      chk(32'(dclk), 32'h0);
      clear();
      tog(0, 4, 8);
      chk(32'(cnt[0]), 32'h0);
      chk(32'(den_cnt_ff), 32'h0);
      bus(1'b1, OFS_CTRL, 32'he8);
      bus(1'b1, OFS_CMUX0 + REG_STRIDE, 32'h7654_3218);
      clear();
      tog(0, 4, 8);
      chk(32'(cnt[1]), 32'h0);
      chk(32'(cnt[2]), 32'h4);
      bus(1'b1, OFS_CTRL, 32'hf8);
      bus(1'b1, OFS_CMUX0, 32'h1054_3210);
      clear();
      fork
         tog(0, 4, 12);
         tog(1, 3, 16);
         begin
            repeat (41) @(posedge clk);
            bus(1'b1, OFS_DCS, 32'h1);
         end
      join
      chk(32'(min_hi), 32'h3);
      rdchk(OFS_DCS, 32'h1);
      rdchk(OFS_STAT, 32'h0000_0101);
      clear();
      tog(0, 4, 8);
      chk(32'(cnt[3]), 32'h0);
      clear();
      tog(1, 3, 8);
      chk(32'(cnt[3]), 32'h8);
      bus(1'b1, OFS_DCS, 32'h2);
      bus(1'b1, OFS_CMUX0, CMUX_RST);
      for (int c = 0; c < 32; c++) begin
         p = c[0] ? 8'h5a : 8'ha5;
         src <= p;
         sec <= ~p;
         bus(1'b1, OFS_SLICE0, {25'h0, 3'(c >> 1), 4'(c >> 1)});
         repeat (10) @(posedge clk);
         chk(32'(slc[0]), 32'(exp_clk(c >> 1, p)));
         chk(32'(sctl[0]), 32'(exp_ctl((c >> 1) & 7, p)));
      end
      print_verdict();
   end
endmodule : cdgs_top_test
